// [rtl/clk_seq_pkg.sv]
// constants, field layout and state codes of the clock return sequencer
// assumes a single 125 MHz bus clock; oscillator edges arrive as pulses
package clk_seq_pkg;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int CPU_STARTUP_NS  = 5000;
  localparam int CPU_STARTUP_CYC = (CPU_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FREQ_STABLE_NS  = 4000000;
  localparam int FREQ_STABLE_CYC = FREQ_STABLE_NS / CLK_PERIOD_NS;
  localparam int OST_EDGES       = 1024;
  localparam int HOLD_EDGES      = 8;

  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] SEC_OFS  = 32'h0000_0004;
  localparam logic [31:0] STAT_OFS = 32'h0000_0008;
  localparam logic [2:0]  SIZE_WORD = 3'h2;

  localparam int CTRL_SEL_LSB  = 0;
  localparam int CTRL_FREQ_LSB = 4;
  localparam int SEC_EN_BIT    = 0;
  localparam int SECONDARY_RUN_MODE_BIT   = 1;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_FS_BIT   = 1;
  localparam int STAT_HOLD_BIT = 2;
  localparam int STAT_CPU_BIT  = 3;
  localparam int STAT_SRC_LSB  = 4;

  localparam logic [1:0] SEL_PRI = 2'h0;
  localparam logic [1:0] SEL_SEC = 2'h1;
  localparam logic [1:0] SEL_INT = 2'h2;
  localparam logic [1:0] SEL_BAD = 2'h3;
  localparam logic [2:0] FREQ_SLOW = 3'h0;

  localparam logic [2:0] CFG_LP  = 3'h0;
  localparam logic [2:0] CFG_XT  = 3'h1;
  localparam logic [2:0] CFG_HS  = 3'h2;
  localparam logic [2:0] CFG_EC  = 3'h3;
  localparam logic [2:0] CFG_RC  = 3'h4;
  localparam logic [2:0] CFG_INT = 3'h5;

  localparam logic [1:0] IDX_CTRL = 2'h0;
  localparam logic [1:0] IDX_SEC  = 2'h1;
  localparam logic [1:0] IDX_STAT = 2'h2;
  localparam logic [1:0] IDX_NONE = 2'h3;

  typedef enum logic [2:0] {
    ST_RST_START = 3'h0,
    ST_RST_WAIT  = 3'h1,
    ST_RST_EXTRA = 3'h3,
    ST_RUN       = 3'h2,
    ST_OST_WAIT  = 3'h6,
    ST_Q1_HOLD   = 3'h7,
    ST_SW_ALT    = 3'h5
  } seq_state_type;
endpackage : clk_seq_pkg

// [rtl/count_if.sv]
// clear, tick and done between the sequencer and its counters
// assumes the owner drives clear and tick in the same clock domain
`timescale 1ns/1ns
`default_nettype none
interface count_if;
  logic clear;
  logic tick;
  logic done;
  modport owner (output clear, output tick, input done);
  modport counter (input clear, input tick, output done);
endinterface : count_if
`default_nettype wire

// [rtl/osc_edge_counter.sv]
// sticky counter of oscillator edge pulses or enabled clock cycles
// assumes tick is a one-cycle pulse or a run level from the owner
`timescale 1ns/1ns
`default_nettype none
module osc_edge_counter #(
  parameter int TARGET = 8
) (
  input wire logic clk,
  input wire logic rst,
  count_if.counter cnt
);
  localparam int W = $clog2(TARGET + 1);
  typedef struct packed {
    logic [W-1:0] n;
    logic         done;
  } cnt_state_type;
  cnt_state_type q;
  cnt_state_type d;

  always_comb begin
    d = q;
    if (cnt.clear) begin
      d = '0;
    end else if (cnt.tick && !q.done) begin
      d.n    = q.n + W'(1);
      d.done = (q.n == W'(TARGET - 1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cnt.done = q.done;
endmodule : osc_edge_counter
`default_nettype wire

// [rtl/primary_clock_return_sequencer.sv]
// clock source sequencer with an AHB-Lite register slave
// assumes oscillator falling edges arrive as one-cycle pulses on clk
`timescale 1ns/1ns
`default_nettype none
module primary_clock_return_sequencer #(
  parameter int FREQ_STABLE_CYCLES = clk_seq_pkg::FREQ_STABLE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [2:0]  primCfg,
  input  wire logic        twoSpeedEn,
  input  wire logic        wdtUsesSlow,
  input  wire logic        fscmUsesSlow,
  input  wire logic        resetFromSleep,
  input  wire logic        primFall,
  input  wire logic        secFall,
  input  wire logic        intFall,
  output logic      [1:0]  sysClkSrc,
  output logic             q1Hold,
  output logic             cpuRun,
  output logic             primaryOscEn,
  output logic             secondaryOscEn,
  output logic             internalOscEn
);
  typedef struct packed {
    clk_seq_pkg::seq_state_type state;
    logic [1:0]  sel;
    logic [2:0]  freqSel;
    logic        secEn;
    logic [1:0]  src;
    logic [1:0]  target;
    logic        fromSleep;
    logic        startupDone;
    logic        freqStable;
    logic        secondary_clock_running_flag;
    logic        q1Hold;
    logic        cpuRun;
    logic        primEn;
    logic        secOscEn;
    logic        intOscEn;
    logic        wrPend;
    logic [1:0]  wrIdx;
    logic        ready;
    logic [31:0] rdata;
  } seq_reg_type;

  seq_reg_type q;
  seq_reg_type d;
  count_if ostIf ();
  count_if edgeIf ();
  count_if cpuIf ();
  count_if fsIf ();

  logic       crystal;
  logic       needCpu;
  logic       inReset;
  logic [1:0] addrIdx;

  assign crystal = (primCfg == clk_seq_pkg::CFG_LP) || (primCfg == clk_seq_pkg::CFG_XT)
                   || (primCfg == clk_seq_pkg::CFG_HS);
  // non-crystal also waits out the CPU delay
  assign needCpu = q.fromSleep || !crystal;
  assign inReset = (q.state == clk_seq_pkg::ST_RST_START) || (q.state == clk_seq_pkg::ST_RST_WAIT)
                   || (q.state == clk_seq_pkg::ST_RST_EXTRA);
  assign addrIdx = (haddr == clk_seq_pkg::CTRL_OFS) ? clk_seq_pkg::IDX_CTRL :
                   (haddr == clk_seq_pkg::SEC_OFS)  ? clk_seq_pkg::IDX_SEC  :
                   (haddr == clk_seq_pkg::STAT_OFS) ? clk_seq_pkg::IDX_STAT : clk_seq_pkg::IDX_NONE;

  osc_edge_counter #(.TARGET(clk_seq_pkg::OST_EDGES)) ostCnt (
    .clk (clk),
    .rst (rst),
    .cnt (ostIf.counter)
  );
  osc_edge_counter #(.TARGET(clk_seq_pkg::HOLD_EDGES)) edgeCnt (
    .clk (clk),
    .rst (rst),
    .cnt (edgeIf.counter)
  );
  osc_edge_counter #(.TARGET(clk_seq_pkg::CPU_STARTUP_CYC)) cpuCnt (
    .clk (clk),
    .rst (rst),
    .cnt (cpuIf.counter)
  );
  osc_edge_counter #(.TARGET(FREQ_STABLE_CYCLES)) fsCnt (
    .clk (clk),
    .rst (rst),
    .cnt (fsIf.counter)
  );

  always_comb begin
    logic [1:0] newSel;
    newSel = q.sel;
    d = q;
    d.wrPend = 1'b0;
    ostIf.clear = 1'b0;
    ostIf.tick = 1'b0;
    edgeIf.clear = 1'b0;
    edgeIf.tick = 1'b0;
    cpuIf.clear = 1'b0;
    cpuIf.tick = 1'b0;
    fsIf.clear = 1'b0;
    fsIf.tick = (q.state == clk_seq_pkg::ST_RUN) && (q.src == clk_seq_pkg::SEL_INT);

    // data phase of a write
    if (q.wrPend && q.wrIdx == clk_seq_pkg::IDX_CTRL) begin
      newSel = hwdata[clk_seq_pkg::CTRL_SEL_LSB +: 2];
      // reserved code 11 folds onto the internal clock
      if (newSel == clk_seq_pkg::SEL_BAD) begin
        newSel = clk_seq_pkg::SEL_INT;
      end
      if (!q.secEn) begin
        newSel[0] = 1'b0;
      end
      d.sel = newSel;
      d.freqSel = hwdata[clk_seq_pkg::CTRL_FREQ_LSB +: 3];
    end
    if (q.wrPend && q.wrIdx == clk_seq_pkg::IDX_SEC) begin
      d.secEn = hwdata[clk_seq_pkg::SEC_EN_BIT];
      // enable cleared drops select low bit
      if (!hwdata[clk_seq_pkg::SEC_EN_BIT]) begin
        d.sel[0] = 1'b0;
      end
    end

    unique case (q.state)
      clk_seq_pkg::ST_RST_START: begin
        d.fromSleep = resetFromSleep;
        ostIf.clear = 1'b1;
        cpuIf.clear = 1'b1;
        d.state = clk_seq_pkg::ST_RST_WAIT;
        // two-speed start runs from internal clock
        if (crystal && twoSpeedEn) begin
          d.src = clk_seq_pkg::SEL_INT;
          d.cpuRun = 1'b1;
          d.q1Hold = 1'b0;
        end
      end
      clk_seq_pkg::ST_RST_WAIT: begin
        // both timers run side by side
        cpuIf.tick = needCpu;
        ostIf.tick = crystal && primFall;
        if ((cpuIf.done || !needCpu) && (ostIf.done || !crystal)) begin
          d.state = clk_seq_pkg::ST_RST_EXTRA;
        end
      end
      clk_seq_pkg::ST_RST_EXTRA: begin
        d.state = clk_seq_pkg::ST_RUN;
        d.src = clk_seq_pkg::SEL_PRI;
        d.cpuRun = 1'b1;
        d.q1Hold = 1'b0;
        d.startupDone = 1'b1;
      end
      clk_seq_pkg::ST_RUN: begin
        // stable flag after 4 ms on fast internal clock
        if (q.src == clk_seq_pkg::SEL_INT && q.freqSel != clk_seq_pkg::FREQ_SLOW && fsIf.done) begin
          d.freqStable = 1'b1;
        end
      end
      clk_seq_pkg::ST_OST_WAIT: begin
        // execution keeps the current clock here
        ostIf.tick = primFall;
        if (ostIf.done) begin
          d.state = clk_seq_pkg::ST_Q1_HOLD;
          d.q1Hold = 1'b1;
        end
      end
      clk_seq_pkg::ST_Q1_HOLD: begin
        // eight primary falling edges in hold
        edgeIf.tick = primFall;
        if (edgeIf.done) begin
          d.state = clk_seq_pkg::ST_RUN;
          d.src = clk_seq_pkg::SEL_PRI;
          d.q1Hold = 1'b0;
          d.startupDone = 1'b1;
          d.secondary_clock_running_flag = 1'b0;
        end
      end
      clk_seq_pkg::ST_SW_ALT: begin
        // eight clocks of the new source
        edgeIf.tick = (q.target == clk_seq_pkg::SEL_SEC) ? secFall : intFall;
        if (edgeIf.done) begin
          d.state = clk_seq_pkg::ST_RUN;
          d.src = q.target;
          d.q1Hold = 1'b0;
          d.secondary_clock_running_flag = (q.target == clk_seq_pkg::SEL_SEC);
        end
      end
    endcase

    // a select change starts a transition
    if (!inReset && (d.sel != q.sel || (q.state == clk_seq_pkg::ST_RUN && q.sel != q.src))) begin
      d.target = d.sel;
      if (d.sel == q.src) begin
        d.state = clk_seq_pkg::ST_RUN;
        d.q1Hold = 1'b0;
      end else begin
        ostIf.clear = 1'b1;
        edgeIf.clear = 1'b1;
        fsIf.clear = 1'b1;
        d.startupDone = 1'b0;
        d.freqStable = 1'b0;
        if (d.sel != clk_seq_pkg::SEL_PRI) begin
          d.state = clk_seq_pkg::ST_SW_ALT;
          d.q1Hold = 1'b1;
        end else if (crystal) begin
          d.state = clk_seq_pkg::ST_OST_WAIT;
          d.q1Hold = 1'b0;
        end else begin
          // no start-up wait for these sources
          d.state = clk_seq_pkg::ST_Q1_HOLD;
          d.q1Hold = 1'b1;
        end
      end
    end

    d.primEn = (d.src == clk_seq_pkg::SEL_PRI) || (d.target == clk_seq_pkg::SEL_PRI);
    // secondary stays on only while enabled or in use
    d.secOscEn = d.secEn || (d.src == clk_seq_pkg::SEL_SEC);
    // slow oscillator off unless someone needs it
    d.intOscEn = wdtUsesSlow || fscmUsesSlow || (d.src == clk_seq_pkg::SEL_INT)
                 || (d.target == clk_seq_pkg::SEL_INT) || (primCfg == clk_seq_pkg::CFG_INT && d.primEn);

    // address phase; zero wait states, reads see this cycle's write
    d.ready = 1'b1;
    if (hsel && htrans[1] && hready) begin
      d.wrPend = hwrite && (hsize == clk_seq_pkg::SIZE_WORD);
      d.wrIdx = addrIdx;
      if (!hwrite) begin
        d.rdata = '0;
        if (hsize == clk_seq_pkg::SIZE_WORD) begin
          if (addrIdx == clk_seq_pkg::IDX_CTRL) begin
            d.rdata[clk_seq_pkg::CTRL_SEL_LSB +: 2] = d.sel;
            d.rdata[clk_seq_pkg::CTRL_FREQ_LSB +: 3] = d.freqSel;
          end
          if (addrIdx == clk_seq_pkg::IDX_SEC) begin
            d.rdata[clk_seq_pkg::SEC_EN_BIT] = d.secEn;
            d.rdata[clk_seq_pkg::SECONDARY_RUN_MODE_BIT] = q.secondary_clock_running_flag;
          end
          if (addrIdx == clk_seq_pkg::IDX_STAT) begin
            d.rdata[clk_seq_pkg::STAT_DONE_BIT] = q.startupDone;
            d.rdata[clk_seq_pkg::STAT_FS_BIT] = q.freqStable;
            d.rdata[clk_seq_pkg::STAT_HOLD_BIT] = q.q1Hold;
            d.rdata[clk_seq_pkg::STAT_CPU_BIT] = q.cpuRun;
            d.rdata[clk_seq_pkg::STAT_SRC_LSB +: 2] = q.src;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // reset lands on primary with no transition
      q <= '{state: clk_seq_pkg::ST_RST_START, sel: clk_seq_pkg::SEL_PRI, freqSel: clk_seq_pkg::FREQ_SLOW,
             src: clk_seq_pkg::SEL_PRI, target: clk_seq_pkg::SEL_PRI, q1Hold: 1'b1, primEn: 1'b1,
             ready: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign hrdata = q.rdata;
  assign hreadyout = q.ready;
  assign hresp = 1'b0;
  assign sysClkSrc = q.src;
  assign q1Hold = q.q1Hold;
  assign cpuRun = q.cpuRun;
  assign primaryOscEn = q.primEn;
  assign secondaryOscEn = q.secOscEn;
  assign internalOscEn = q.intOscEn;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_RESET_SEL: assert property ($past(rst) |-> q.sel == clk_seq_pkg::SEL_PRI)
    else $error("select not 00 after reset");
  AST_NO_OST_SKIP: assert property (q.state == clk_seq_pkg::ST_OST_WAIT |-> crystal)
    else $error("start-up wait with non-crystal primary");
  AST_OST_DONE: assert property (
    (q.state == clk_seq_pkg::ST_Q1_HOLD && $past(q.state) == clk_seq_pkg::ST_OST_WAIT) |-> $past(ostIf.done))
    else $error("hold entered before start-up count");
  AST_HOLD_RELEASE: assert property (
    ($fell(q.q1Hold) && $past(q.state) == clk_seq_pkg::ST_Q1_HOLD && $changed(q.src)) |-> $past(edgeIf.done))
    else $error("hold released before eight edges");
  AST_SLOW_OFF: assert property (
    (q.state == clk_seq_pkg::ST_RUN && q.src == clk_seq_pkg::SEL_PRI && q.target == q.src
     && primCfg != clk_seq_pkg::CFG_INT && !wdtUsesSlow && !fscmUsesSlow
     && $stable(primCfg) && $stable(wdtUsesSlow) && $stable(fscmUsesSlow)) |-> !q.intOscEn)
    else $error("slow oscillator left on");
  AST_SEC_OFF: assert property ((!q.secEn && q.src != clk_seq_pkg::SEL_SEC) |-> !q.secOscEn)
    else $error("secondary left running");
  AST_EXTRA_CYCLE: assert property (
    q.state == clk_seq_pkg::ST_RST_EXTRA |-> !q.startupDone ##1 (q.cpuRun && q.startupDone))
    else $error("no extra cycle before run");
  AST_DONE_PRIMARY: assert property (q.startupDone |-> q.src == clk_seq_pkg::SEL_PRI)
    else $error("done flag without primary clock");
  AST_SECONDARY_CLOCK_RUNNING_FLAG_SRC: assert property (q.secondary_clock_running_flag |-> q.src == clk_seq_pkg::SEL_SEC)
    else $error("running flag without secondary clock");
  AST_SEL_FOLD: assert property (!q.secEn |-> !q.sel[0])
    else $error("select low bit set while disabled");

  COV_CRYSTAL_RETURN: cover property (
    q.state == clk_seq_pkg::ST_Q1_HOLD && $past(q.state) == clk_seq_pkg::ST_OST_WAIT);
  COV_TO_SECONDARY: cover property ($rose(q.secondary_clock_running_flag));
  COV_TWO_SPEED: cover property (q.state == clk_seq_pkg::ST_RST_WAIT && q.src == clk_seq_pkg::SEL_INT);
endmodule : primary_clock_return_sequencer
`default_nettype wire

// [test/osc_source_model.sv]
// behavioural oscillator sources, one falling-edge pulse per period
// assumes the sequencer's power enables are registered on clk
`timescale 1ns/1ns
`default_nettype none
module osc_source_model (
  input  wire logic clk,
  input  wire logic slowOsc,
  input  wire logic primaryOscEn,
  input  wire logic secondaryOscEn,
  input  wire logic internalOscEn,
  output var  logic primFall,
  output var  logic secFall,
  output var  logic intFall
);
  int primCnt = 0;
  int secCnt  = 0;
  int intCnt  = 0;

  initial begin
    primFall = 1'b0;
    secFall  = 1'b0;
    intFall  = 1'b0;
  end

  // edges only while powered
  // a stopped oscillator gives no edges at all, so a switch cannot finish early
  always @(posedge clk) begin
    primCnt  <= (!primaryOscEn || primCnt >= (slowOsc ? 5 : 2)) ? 0 : primCnt + 1;
    secCnt   <= (!secondaryOscEn || secCnt >= (slowOsc ? 9 : 4)) ? 0 : secCnt + 1;
    intCnt   <= (!internalOscEn || intCnt >= (slowOsc ? 7 : 3)) ? 0 : intCnt + 1;
    primFall <= primaryOscEn && primCnt == 0;
    secFall  <= secondaryOscEn && secCnt == 0;
    intFall  <= internalOscEn && intCnt == 0;
  end
endmodule : osc_source_model
`default_nettype wire

// [test/primary_clock_return_sequencer_tb.sv]
// self-checking bench for the clock return sequencer
// assumes one slave on the bus, so hreadyout feeds hready back
`timescale 1ns/1ns
`default_nettype none
module primary_clock_return_sequencer_tb;
  localparam int FS_CYC = 20;
  localparam int LIMIT  = 40000;
  typedef struct {
    logic        doWrite;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] expVal;
  } row_type;

  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, sysClkSrc;
  logic [2:0]  hsize, primCfg;
  logic        twoSpeedEn, wdtUsesSlow, fscmUsesSlow, resetFromSleep, slowOsc;
  logic        primFall, secFall, intFall, q1Hold, cpuRun;
  logic        primaryOscEn, secondaryOscEn, internalOscEn;
  int          failCount, comparisons, cycles, n;
  row_type     rows [5];

  assign hready = hreadyout;

  primary_clock_return_sequencer #(.FREQ_STABLE_CYCLES(FS_CYC)) dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .primCfg(primCfg), .twoSpeedEn(twoSpeedEn), .wdtUsesSlow(wdtUsesSlow),
    .fscmUsesSlow(fscmUsesSlow), .resetFromSleep(resetFromSleep), .primFall(primFall),
    .secFall(secFall), .intFall(intFall), .sysClkSrc(sysClkSrc), .q1Hold(q1Hold),
    .cpuRun(cpuRun), .primaryOscEn(primaryOscEn), .secondaryOscEn(secondaryOscEn),
    .internalOscEn(internalOscEn)
  );

  osc_source_model osc (
    .clk(clk), .slowOsc(slowOsc), .primaryOscEn(primaryOscEn), .secondaryOscEn(secondaryOscEn),
    .internalOscEn(internalOscEn), .primFall(primFall), .secFall(secFall), .intFall(intFall)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  // hang guard, sized well above the longest sequence of runs
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failCount++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic busAccess(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : busAccess

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    busAccess(1'b1, a, d, q);
  endtask : wr

  task automatic rdCheck(input logic [31:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    busAccess(1'b0, a, 32'h0, q);
    check(q & mask, exp);
  endtask : rdCheck

  task automatic waitSrc(input logic [1:0] s, input int lim, output int cnt);
    cnt = 0;
    while (sysClkSrc !== s && cnt < lim) begin
      @(posedge clk);
      cnt++;
    end
    check({30'h0, sysClkSrc}, {30'h0, s});
  endtask : waitSrc

  task automatic doReset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask : doReset

  initial begin
    {rst, hsel, hwrite, twoSpeedEn, wdtUsesSlow, fscmUsesSlow, resetFromSleep, slowOsc} = 8'h80;
    haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hsize = 3'h2;
    primCfg = clk_seq_pkg::CFG_XT;
    failCount = 0; comparisons = 0; cycles = 0;
    rows[0] = '{1'b0, clk_seq_pkg::CTRL_OFS, 32'h0, 32'h0};
    rows[1] = '{1'b1, clk_seq_pkg::SEC_OFS, 32'h1, 32'h1};
    rows[2] = '{1'b1, 32'h0000_000C, 32'hFFFF_FFFF, 32'h0};
    rows[3] = '{1'b1, clk_seq_pkg::STAT_OFS, 32'hFF, 32'h09};
    rows[4] = '{1'b1, clk_seq_pkg::CTRL_OFS, 32'hFFFF_FF70, 32'h70};
    doReset();
    @(negedge clk);
    check({30'h0, sysClkSrc, q1Hold, cpuRun}, 32'h2);
    repeat (3000) @(posedge clk);
    check({31'h0, cpuRun}, 32'h0);
    n = 0;
    while (cpuRun !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, cpuRun}, 32'h1);
    // plain register accesses
    foreach (rows[i]) begin
      if (rows[i].doWrite) wr(rows[i].addr, rows[i].wdata);
      rdCheck(rows[i].addr, 32'hFFFF_FFFF, rows[i].expVal);
    end
    check({31'h0, hresp}, 32'h0);
    wr(clk_seq_pkg::CTRL_OFS, 32'h71);
    @(negedge clk);
    check({31'h0, q1Hold}, 32'h1);
    waitSrc(2'h1, 300, n);
    rdCheck(clk_seq_pkg::SEC_OFS, 32'hFFFF_FFFF, 32'h3);
    rdCheck(clk_seq_pkg::STAT_OFS, 32'hFFFF_FFFF, 32'h18);
    wr(clk_seq_pkg::SEC_OFS, 32'h0);
    rdCheck(clk_seq_pkg::CTRL_OFS, 32'hFFFF_FFFF, 32'h70);
    @(negedge clk);
    check({29'h0, sysClkSrc, secondaryOscEn}, 32'h3);
    check({30'h0, cpuRun, q1Hold}, 32'h2);
    waitSrc(2'h0, 5000, n);
    check({31'h0, n > 2900}, 32'h1);
    @(negedge clk);
    check({31'h0, secondaryOscEn}, 32'h0);
    rdCheck(clk_seq_pkg::STAT_OFS, 32'hFFFF_FFFF, 32'h09);
    // slow internal oscillator: eight edges take at least 56 cycles
    slowOsc <= 1'b1;
    wr(clk_seq_pkg::CTRL_OFS, 32'h12);
    waitSrc(2'h2, 400, n);
    check({31'h0, n >= 56}, 32'h1);
    check({31'h0, primaryOscEn}, 32'h0);
    rdCheck(clk_seq_pkg::STAT_OFS, 32'hFFFF_FFFF, 32'h28);
    repeat (FS_CYC) @(posedge clk);
    rdCheck(clk_seq_pkg::STAT_OFS, 32'hFFFF_FFFF, 32'h2A);
    rdCheck(clk_seq_pkg::SEC_OFS, 32'hFFFF_FFFF, 32'h0);
    slowOsc <= 1'b0;
    wr(clk_seq_pkg::CTRL_OFS, 32'h10);
    waitSrc(2'h0, 5000, n);
    @(negedge clk);
    check({31'h0, internalOscEn}, 32'h0);
    rdCheck(clk_seq_pkg::STAT_OFS, 32'h31, 32'h01);
    // non-crystal primary, reset out of sleep
    primCfg        <= clk_seq_pkg::CFG_EC;
    resetFromSleep <= 1'b1;
    doReset();
    repeat (615) @(posedge clk);
    @(negedge clk);
    check({30'h0, cpuRun, q1Hold}, 32'h1);
    n = 0;
    while (cpuRun !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, cpuRun}, 32'h1);
    wr(clk_seq_pkg::CTRL_OFS, 32'h2);
    waitSrc(2'h2, 300, n);
    wr(clk_seq_pkg::CTRL_OFS, 32'h0);
    waitSrc(2'h0, 200, n);
    check({31'h0, n < 100}, 32'h1);
    // crystal with two-speed start-up, monitor keeps slow clock
    primCfg        <= clk_seq_pkg::CFG_HS;
    resetFromSleep <= 1'b0;
    twoSpeedEn     <= 1'b1;
    fscmUsesSlow   <= 1'b1;
    doReset();
    repeat (100) @(posedge clk);
    @(negedge clk);
    check({29'h0, sysClkSrc, cpuRun}, 32'h5);
    waitSrc(2'h0, 4000, n);
    @(negedge clk);
    check({31'h0, internalOscEn}, 32'h1);
    stop_test();
  end
endmodule : primary_clock_return_sequencer_tb
`default_nettype wire
